// *** rtl/rtc_bus_access_hold.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// - Time carries are held from start until stop or forced release for a coherent snapshot.
// - A held carry is applied within about 61 us after stop.
// - Access open 0.5 to 1.0 s after start is released automatically.
// - Forced release loads pointer with Fh, acting like a received stop.
// - Repeated start does not restart the timeout; it counts from first start.
// - After forced release, writes get no acknowledge and reads return FFh.
// - A free-running 32 kHz square clock is driven out.
// - Every stop sets the address pointer to Fh.
// - Pointer increments after each data byte until a forced release, wrapping Fh to 0h.
module rtc_bus_access_hold_timeout #(
  parameter int CLK_HZ           = rtc_hold_pkg::CLK_HZ_DEFAULT,
  parameter int HALF_SEC_EDGES   = rtc_hold_pkg::HALF_SEC_EDGES,
  parameter int CARRY_WINDOW_CYC = rtc_hold_pkg::CARRY_WINDOW_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       start_seen,
  input  wire logic       stop_seen,
  input  wire logic       ptr_write,
  input  wire logic [3:0] ptr_value,
  input  wire logic       data_byte_done,
  input  wire logic [7:0] rd_data_in,
  output logic            square_clock_out,
  output logic            counter_freeze,
  output logic            carry_apply,
  output logic [3:0]      addr_ptr,
  output logic            ack_enable,
  output logic [7:0]      rd_data_out,
  output logic            access_released
);
  import rtc_hold_pkg::*;

  // Held carry must land inside the window even if the window is shortened
  if (CARRY_WINDOW_CYC < CARRY_APPLY_CYC) begin : g_check
    $error("rtc_bus_access_hold_timeout: carry window shorter than apply delay");
  end

  typedef struct packed {
    access_e    state;
    logic [1:0] ticks;
    logic       pending;
    logic       carry;
    logic [3:0] ptr;
    logic       ack;
    logic [7:0] rd;
    logic       square;
    logic       freeze;
    logic       released;
  } hold_s;

  hold_s st;
  hold_s next_st;

  time_base_if tb ();

  // ==========================================================================
  // Time base
  // ==========================================================================
  rtc_time_base #(
    .CLK_HZ         (CLK_HZ),
    .HALF_SEC_EDGES (HALF_SEC_EDGES)
  ) u_time_base (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tb      (tb.source)
  );

  // ==========================================================================
  // Access state, pointer, carry hold and refusal
  // ==========================================================================
  always_comb begin
    next_st       = st;
    next_st.carry = 1'b0;

    // Pointer follows host traffic; frozen once the access has been refused
    if (st.state != acc_released) begin
      if (ptr_write) begin
        next_st.ptr = ptr_value;
      end else if (data_byte_done) begin
        next_st.ptr = st.ptr + PTR_STEP;
      end
    end

    unique case (st.state)
      acc_idle: begin
        if (start_seen && !stop_seen) begin
          next_st.state = acc_open;
          next_st.ticks = '0;
        end
      end
      acc_open: begin
        // A start here is a repeated start and leaves the tick count alone
        if (stop_seen) begin
          next_st.state = acc_idle;
        end else if (tb.half_tick) begin
          next_st.ticks = st.ticks + 2'h1;
          if (st.ticks == 2'(TIMEOUT_TICKS - 2'h1)) begin
            next_st.state = acc_released;
            next_st.ptr   = PTR_AFTER_STOP;
          end
        end
      end
      acc_released: begin
        if (stop_seen) begin
          next_st.state = acc_idle;
        end
      end
    endcase

    // Stop always parks the pointer, whatever the state
    if (stop_seen) begin
      next_st.ptr = PTR_AFTER_STOP;
    end

    next_st.freeze   = (next_st.state == acc_open);
    next_st.released = (next_st.state == acc_released);

    // Carry held while frozen; set wins, pending only clears once unfrozen
    if (tb.sec_carry) begin
      if (next_st.freeze) begin
        next_st.pending = 1'b1;
      end else begin
        next_st.carry = 1'b1;
      end
    end
    if (st.pending && !next_st.freeze) begin
      next_st.carry   = 1'b1;
      next_st.pending = 1'b0;
    end

    // Refused access: no acknowledge and all-ones read data
    next_st.ack    = !next_st.released;
    next_st.rd     = next_st.released ? READ_REFUSED : rd_data_in;
    next_st.square = tb.square;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st     <= '0;
      st.ptr <= PTR_RESET;
      st.ack <= 1'b1;
      st.rd  <= READ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register
  assign square_clock_out = st.square;
  assign counter_freeze   = st.freeze;
  assign carry_apply      = st.carry;
  assign addr_ptr         = st.ptr;
  assign ack_enable       = st.ack;
  assign rd_data_out      = st.rd;
  assign access_released  = st.released;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_first_start;
    st.state == acc_idle && start_seen && !stop_seen;
  endsequence

  sequence s_second_tick;
    st.state == acc_open && tb.half_tick && st.ticks == 2'h1 && !stop_seen;
  endsequence

  sequence s_held_carry;
    st.state == acc_open && tb.sec_carry && st.ticks == 2'h0 && !stop_seen;
  endsequence

  // Open frame that neither stops nor meets its releasing tick in this cycle
  sequence s_stays_open;
    st.state == acc_open && !stop_seen && !(tb.half_tick && st.ticks == 2'h1);
  endsequence

  a_freeze_on_start: assert property (s_first_start |=> counter_freeze)
    else $error("counters not frozen after start");
  a_carry_held: assert property (s_held_carry |=> !carry_apply && st.pending)
    else $error("carry passed while counters frozen");
  a_carry_after_stop: assert property (st.pending && stop_seen |=> carry_apply)
    else $error("held carry not applied after stop");
  a_timeout_release: assert property (s_second_tick |=> access_released && !counter_freeze)
    else $error("access not released on second half-second tick");
  a_timeout_pointer: assert property (s_second_tick |=> addr_ptr == PTR_AFTER_STOP)
    else $error("pointer not parked on forced release");
  a_repeat_start: assert property (
    st.state == acc_open && start_seen && !stop_seen && !tb.half_tick
    |=> st.state == acc_open && $stable(st.ticks))
    else $error("repeated start disturbed the timeout");
  a_refused_access: assert property (
    st.state == acc_released && !stop_seen |=> !ack_enable && rd_data_out == READ_REFUSED)
    else $error("refused access still acknowledged or read");
  a_stop_pointer: assert property (stop_seen |=> addr_ptr == PTR_AFTER_STOP)
    else $error("pointer not parked after stop");
  a_pointer_step: assert property (
    st.state == acc_open && data_byte_done && !ptr_write && !stop_seen && !tb.half_tick
    |=> addr_ptr == 4'($past(addr_ptr) + PTR_STEP))
    else $error("pointer did not step after a data byte");
  a_open_bound: assert property (s_stays_open |=> counter_freeze)
    else $error("freeze ended early without stop or timeout");
  a_no_carry_open: assert property (s_stays_open |=> !carry_apply)
    else $error("carry reached the counters inside an open frame");
  a_idle_start_stop: assert property (
    st.state == acc_idle && start_seen && stop_seen |=> !counter_freeze)
    else $error("start together with stop opened a frame");
  a_square_follow: assert property (tb.osc_edge |=> $changed(square_clock_out))
    else $error("square clock output missed an oscillator edge");
  a_released_hold: assert property (
    st.state == acc_released && !stop_seen |=> $stable(addr_ptr))
    else $error("pointer moved while the access was refused");

endmodule

// *** rtl/rtc_hold_pkg.sv ***
package rtc_hold_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CLK_HZ_DEFAULT   = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int OSC_HZ           = 32768;
  // Edges of the square clock per half second (two edges per oscillator period)
  localparam int HALF_SEC_EDGES   = OSC_HZ;

  // ==========================================================================
  // Access hold timing
  // ==========================================================================
  // Half-second ticks after the first start that force the release
  localparam logic [1:0] TIMEOUT_TICKS    = 2'h2;
  // Longest wait from stop to applying a held carry
  localparam int         CARRY_WINDOW_NS  = 61000;
  localparam int         CARRY_WINDOW_CYC = CARRY_WINDOW_NS / CLK_PERIOD_NS;
  // Cycles the logic really takes from stop to the carry pulse
  localparam int         CARRY_APPLY_CYC  = 1;

  // ==========================================================================
  // Address pointer and refused reads
  // ==========================================================================
  localparam logic [3:0] PTR_RESET      = 4'hf;
  localparam logic [3:0] PTR_AFTER_STOP = 4'hf;
  localparam logic [3:0] PTR_STEP       = 4'h1;
  localparam logic [7:0] READ_REFUSED   = 8'hff;
  localparam logic [7:0] READ_RESET     = 8'h00;

  typedef enum logic [1:0] {
    acc_idle,
    acc_open,
    acc_released
  } access_e;

endpackage

// *** rtl/time_base_if.sv ***
`timescale 1ns/10ps
// ============================================================================
// Time base carrier between the divider and the access hold logic
// ============================================================================
interface time_base_if;
  logic osc_edge;
  logic half_tick;
  logic sec_carry;
  logic square;

  modport source (
    output osc_edge,
    output half_tick,
    output sec_carry,
    output square
  );
  modport sink (
    input  osc_edge,
    input  half_tick,
    input  sec_carry,
    input  square
  );
endinterface

// *** rtl/rtc_time_base.sv ***
`timescale 1ns/10ps
// ============================================================================
// Oscillator emulation: fractional divider from the system clock
// ============================================================================
module rtc_time_base #(
  parameter int CLK_HZ         = rtc_hold_pkg::CLK_HZ_DEFAULT,
  parameter int HALF_SEC_EDGES = rtc_hold_pkg::HALF_SEC_EDGES
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  time_base_if.source        tb
);
  import rtc_hold_pkg::*;

  localparam logic [31:0] STEP  = 32'(2 * OSC_HZ);
  localparam logic [31:0] LIMIT = 32'(CLK_HZ);
  localparam logic [31:0] LAST  = 32'(HALF_SEC_EDGES - 1);

  // Divider must be slower than the system clock to form one-cycle enables
  if (CLK_HZ < 4 * OSC_HZ || HALF_SEC_EDGES < 2) begin : g_check
    $error("rtc_time_base: clock too slow or half-second count too small");
  end

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] edges;
    logic        half_phase;
    logic        osc_edge;
    logic        half_tick;
    logic        sec_carry;
    logic        square;
  } base_s;

  base_s st;
  base_s next_st;

  // ==========================================================================
  // Phase accumulator; averages to the exact rate though steps jitter a cycle
  // ==========================================================================
  always_comb begin
    next_st           = st;
    next_st.osc_edge  = 1'b0;
    next_st.half_tick = 1'b0;
    next_st.sec_carry = 1'b0;
    if (st.acc + STEP >= LIMIT) begin
      next_st.acc      = st.acc + STEP - LIMIT;
      next_st.osc_edge = 1'b1;
      next_st.square   = ~st.square;
      if (st.edges == LAST) begin
        next_st.edges      = '0;
        next_st.half_tick  = 1'b1;
        next_st.half_phase = ~st.half_phase;
        next_st.sec_carry  = st.half_phase; // One carry per two half ticks
      end else begin
        next_st.edges = st.edges + 32'h1;
      end
    end else begin
      next_st.acc = st.acc + STEP;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tb.osc_edge  = st.osc_edge;
  assign tb.half_tick = st.half_tick;
  assign tb.sec_carry = st.sec_carry;
  assign tb.square    = st.square;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_square_edge_cause: assert property ($changed(st.square) |-> st.osc_edge)
    else $error("square clock changed without an oscillator edge");
  // The elaboration check keeps the step ratio at two or more, so edges never touch
  a_square_edge_spacing: assert property (st.osc_edge |=> !st.osc_edge)
    else $error("oscillator edges closer than the divider allows");

endmodule

// *** verification/host_model.sv ***
`timescale 1ns/10ps
// ============================================================================
// Bus master stand-in: emits the front-end event pulses
// ============================================================================
module host_model #(
  parameter int GAP = 6100
) (
  input  wire logic       sys_clk,
  output logic            start_seen,
  output logic            stop_seen,
  output logic            ptr_write,
  output logic [3:0]      ptr_value,
  output logic            data_byte_done
);
  int idle_cyc = 1000000;

  // Cycles since the last stop, so a new frame never lands on a held carry
  always @(posedge sys_clk) idle_cyc <= stop_seen ? 0 : idle_cyc + 1;

  initial {start_seen, stop_seen, ptr_write, ptr_value, data_byte_done} = '0;

  // One-cycle pulse: 0 start, 1 stop, 2 pointer byte, 3 data byte
  task automatic ev(input int kind, input logic [3:0] v);
    @(negedge sys_clk);
    case (kind)
      0: start_seen = 1'b1;
      1: stop_seen = 1'b1;
      2: begin
        ptr_write = 1'b1;
        ptr_value = v;
      end
      default: data_byte_done = 1'b1;
    endcase
    @(negedge sys_clk);
    {start_seen, stop_seen, ptr_write, data_byte_done} = '0;
  endtask

  // Frames stay short unless a test holds one open on purpose
  task automatic open_frame();
    while (idle_cyc < GAP) @(negedge sys_clk);
    ev(0, 4'h0);
  endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
// ============================================================================
// Access hold bench
// ============================================================================
module tb_top;
  import rtc_hold_pkg::*;
  localparam int GAP = 6100;
  logic            sys_clk = 1'b0;
  logic            reset_n = 1'b0;
  logic            start_seen;
  logic            stop_seen;
  logic            ptr_write;
  logic [3:0]      ptr_value;
  logic            data_byte_done;
  logic [7:0]      rd_data_in = 8'h00;
  logic            square_clock_out;
  logic            counter_freeze;
  logic            carry_apply;
  logic [3:0]      addr_ptr;
  logic            ack_enable;
  logic [7:0]      rd_data_out;
  logic            access_released;
  int              mismatches = 0;
  int              checks_done = 0;

  // Clock
  always #5 sys_clk = ~sys_clk;

  host_model #(.GAP(GAP)) host (
    .sys_clk(sys_clk), .start_seen(start_seen), .stop_seen(stop_seen),
    .ptr_write(ptr_write), .ptr_value(ptr_value), .data_byte_done(data_byte_done));

  // Small divider: 16 cycles per half second keeps the timeout short
  rtc_bus_access_hold_timeout #(.CLK_HZ(262144), .HALF_SEC_EDGES(4)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .start_seen(start_seen),
    .stop_seen(stop_seen), .ptr_write(ptr_write), .ptr_value(ptr_value),
    .data_byte_done(data_byte_done), .rd_data_in(rd_data_in),
    .square_clock_out(square_clock_out), .counter_freeze(counter_freeze),
    .carry_apply(carry_apply), .addr_ptr(addr_ptr), .ack_enable(ack_enable),
    .rd_data_out(rd_data_out), .access_released(access_released));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Aligns to the one-second carry; bounded since carries come every 32 cycles
  task automatic wait_carry();
    int n;
    n = 0;
    while (carry_apply !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    check("carry found", 8'h01, 8'(n < 100));
  endtask

  task automatic t_walk();
    host.open_frame();
    check("freeze", 8'h01, 8'(counter_freeze));
    host.ev(2, 4'h2);
    check("ptr", 8'h02, 8'(addr_ptr));
    host.ev(3, 4'h0);
    check("ptr", 8'h03, 8'(addr_ptr));
    rd_data_in = 8'h5a;
    cyc(1);
    check("rdata", 8'h5a, rd_data_out);
    host.ev(2, 4'hf);
    host.ev(3, 4'h0);
    check("ptr wrap", 8'h00, 8'(addr_ptr));
    host.ev(1, 4'h0);
    check("freeze", 8'h00, 8'(counter_freeze));
    check("ptr", 8'h0f, 8'(addr_ptr));
    $display("test walk done");
  endtask

  task automatic t_square();
    int   edges;
    logic last;
    edges = 0;
    last = square_clock_out;
    repeat (64) begin
      cyc(1);
      if (square_clock_out !== last) edges++;
      last = square_clock_out;
    end
    check("square edges", 8'h01, 8'(edges >= 15 && edges <= 17));
    $display("test square done");
  endtask

  // Frame straddles a carry: nothing leaks out until stop, then one pulse
  task automatic t_hold();
    int seen;
    seen = 0;
    cyc(GAP);
    wait_carry();
    cyc(18);
    host.open_frame();
    repeat (14) begin
      cyc(1);
      seen += int'(carry_apply);
    end
    check("carries while open", 8'h00, 8'(seen));
    host.ev(1, 4'h0);
    seen = int'(carry_apply);
    repeat (20) begin
      cyc(1);
      seen += int'(carry_apply);
    end
    check("carries after stop", 8'h01, 8'(seen));
    $display("test hold done");
  endtask

  // Frame left open past the limit, with a repeated start after the first tick
  task automatic t_timeout();
    int n;
    cyc(GAP);
    wait_carry();
    host.open_frame();
    host.ev(2, 4'h3);
    cyc(14);
    host.ev(0, 4'h0);
    n = 18;
    while (access_released !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    check("release delay ok", 8'h01, 8'(n >= 17 && n <= 32));
    check("carry at release", 8'h01, 8'(carry_apply));
    check("freeze", 8'h00, 8'(counter_freeze));
    check("ptr", 8'h0f, 8'(addr_ptr));
    rd_data_in = 8'h12;
    host.ev(2, 4'h5);
    host.ev(3, 4'h0);
    check("ptr", 8'h0f, 8'(addr_ptr));
    check("ack", 8'h00, 8'(ack_enable));
    check("rdata", 8'hff, rd_data_out);
    host.ev(1, 4'h0);
    check("released", 8'h00, 8'(access_released));
    check("ack", 8'h01, 8'(ack_enable));
    check("rdata", 8'h12, rd_data_out);
    $display("test timeout done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the tests need about 13000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    cyc(5);
    reset_n = 1'b1;
    check("ptr", 8'h0f, 8'(addr_ptr));
    check("ack", 8'h01, 8'(ack_enable));
    check("freeze", 8'h00, 8'(counter_freeze));
    $display("test reset done");
    t_walk();
    t_square();
    t_hold();
    t_timeout();
    end_of_test();
  end
endmodule
